// File: common/acdp_cfg.svh
/*
 * constants for the auxiliary control/data port: register offsets,
 * field positions, handshake qualifiers, buffer sizing and counts.
 * assumes it is included by the port module only; the bench uses literal values.
 */
// Functional notes
// [R1] register data uses only low eight bits
// [R2] host address words carry qualifier 00b
// [R3] host write data words carry qualifier 11b
// [R4] read data returned with qualifier 10b
// [R5] host gives three strobes after reset
// [R6] select low, read/write high: register read
// [R7] address latched on rising strobe edge
// [R8] read data driven until next rising edge
// [R9] host releases address before falling edge
// [R10] both low: address, then data next edge
// [R11] packet buffer holds 259 words
// [R12] packets copied without flag, video unchanged
// [R13] high definition: chroma channel only
// [R14] mask and identifier decide packet copy
// [R15] empty, 90% full, full, overrun flags
// [R16] both high: each edge pops one word
// [R17] port never accepts packet data from host
// [R18] register 17h bit 6 gates capture
// [R19] host gives three strobes after enabling
// [R20] eight six-bit pin configuration registers
// [R21] one control per input pin only
// [R22] input pins clocked in by strobe
// [R23] mapped indicators appear on output pins
// [R24] reset clears all registers and counters
// [R25] port drivers off outside read phases
`ifndef ACDP_CFG_SVH
`define ACDP_CFG_SVH
`define ACDP_REG_FFLAGS 8'h01
`define ACDP_REG_TEST 8'h0d
`define ACDP_REG_PIN0 8'h0f
`define ACDP_REG_PIN7 8'h16
`define ACDP_REG_ANCCTL 8'h17
`define ACDP_REG_MASK 8'h18
`define ACDP_REG_IDM 8'h19
`define ACDP_REG_STAT 8'h1a
`define ACDP_FIFOEN_BIT 6
`define ACDP_PIN_DIR_BIT 5
`define ACDP_Q_ADDR 2'h0
`define ACDP_Q_DATA 2'h3
`define ACDP_Q_READ 2'h2
`define ACDP_INIT_EDGES 2'h3
`define ACDP_FIFO_DEPTH 259
`define ACDP_FIFO_AFULL 233
`define ACDP_ADF0 10'h000
`define ACDP_ADF1 10'h3ff
`endif

// File: common/acdp_pkg.sv
/*
 * types for the auxiliary control/data port.
 * assumes nothing beyond a SystemVerilog compiler.
 */
package acdp_pkg;
    typedef enum logic [1:0] {
        PS_IDLE = 2'b00,
        PS_WDATA = 2'b01,
        PS_RDRV = 2'b10
    } acdp_port_t;
    typedef enum logic [2:0] {
        PK_SEEK = 3'b000,
        PK_DID = 3'b001,
        PK_SDID = 3'b010,
        PK_DC = 3'b011,
        PK_BODY = 3'b100
    } acdp_pkt_t;
endpackage

// File: src/acdp_port.sv
/*
 * auxiliary control/data port: strobe-clocked register access, packet
 * extraction into a dual-clock buffer, multi-function pin mapping.
 * assumes aclk is the host strobe and core_clk the video word clock;
 * config registers are quasi-static when crossing to core_clk.
 */
`timescale 1ns/1ps
`include "acdp_cfg.svh"
module acdp_port
    import acdp_pkg::*;
#(
    parameter int DEPTH = `ACDP_FIFO_DEPTH,
    parameter int AFULL = `ACDP_FIFO_AFULL,
    parameter int AW = 9
) (
    input wire logic core_clk, // video word clock
    input wire logic nrst, // async reset, low
    input wire logic aclk, // host port strobe clock
    input wire logic portFnSel, // high: packet buffer mode
    input wire logic rdWrSel, // high: read
    input wire logic [9:0] adIn, // port pins, input side
    output logic [9:0] adOut, // port pins, output side
    output logic adOe, // port pins drive enable
    input wire logic [7:0] ioIn, // multi-function pins in
    output logic [7:0] ioOut, // multi-function pins out
    output logic [7:0] ioOe, // multi-function pins enable
    input wire logic [19:0] videoIn, // recovered video words
    input wire logic videoValid, // video word valid
    input wire logic [4:0] fieldFlags, // error checker flags
    output logic [9:0] chromaVideoOut // chroma passthrough
);
    // gray encode used on both pointers, decode on the read pointer only
    function automatic logic [AW:0] bin2gray(input logic [AW:0] b);
        return b ^ (b >> 1);
    endfunction
    function automatic logic [AW:0] gray2bin(input logic [AW:0] g);
        logic [AW:0] b;
        b = g;
        for (int i = AW - 1; i >= 0; i--) begin
            b[i] = b[i + 1] ^ g[i];
        end
        return b;
    endfunction

    // aclk domain state
    logic [1:0] initCnt; // strobes seen since reset
    logic portReady; // port initialised
    acdp_port_t state; // register access phase
    logic [7:0] addr; // latched register address
    logic [7:0] rdData; // selected register contents
    logic [7:0] testCtl; // test_pattern_control
    logic [7:0] ancCtl; // ancillary_fifo_control
    logic [7:0] copyMask; // packet_copy_mask
    logic [7:0] idMatch; // packet_id_match
    logic [5:0] pinCfg [8]; // io pin function selects
    logic [7:0] pinVal; // per-pin mapped value
    logic [4:0] ffS1, ffS2; // field flags sync
    logic [2:0] stS1, stS2; // core buffer flags sync
    logic [7:0] ioS1, ioS2; // input pins sync
    logic [AW:0] wgS1, wgS2; // write pointer sync
    logic [AW:0] rptr, rgray; // read pointer
    logic empty; // packet_buffer_empty_flag
    logic pop; // buffer word taken this edge
    logic wrEn; // register write this edge
    logic [7:0] statReg; // buffer status byte

    // core_clk domain state
    logic [32:0] xS1, xS2; // config and pin levels sync
    logic [AW:0] rgS1, rgS2; // read pointer sync
    logic [AW:0] wptr, wgray; // write pointer
    logic [AW:0] occ; // words held, core view
    logic full, aFull, overrun; // buffer flags
    acdp_pkt_t pk; // packet parser phase
    logic [1:0] adfCnt; // flag words matched
    logic [8:0] remain; // words left in packet
    logic keep; // current packet is copied
    logic hit; // identifier passes filter
    logic wrReq, wrDo; // buffer write request/do
    logic [9:0] chroma; // channel carrying packets
    logic [9:0] mem [0:(1 << AW) - 1]; // packet buffer

    // function index: [4:3] register group, [2:0] bit
    function automatic logic mapBit(input logic [4:0] s, input logic [7:0] t,
            input logic [7:0] a, input logic [7:0] st, input logic [4:0] ff);
        logic [7:0] g;
        unique case (s[4:3])
            2'h0: g = t;
            2'h1: g = a;
            2'h2: g = st;
            default: g = {3'h0, ff};
        endcase
        return g[s[2:0]];
    endfunction

    // port is unusable until three strobes after reset
    always_ff @(posedge aclk or negedge nrst) begin
        if (!nrst) begin
            initCnt <= 2'h0; // [R24]
        end else if (initCnt != `ACDP_INIT_EDGES) begin
            initCnt <= initCnt + 2'h1; // [R5]
        end
    end
    assign portReady = (initCnt == `ACDP_INIT_EDGES);

    // synchronisers into aclk domain
    always_ff @(posedge aclk or negedge nrst) begin
        if (!nrst) begin
            ffS1 <= 5'h00;
            ffS2 <= 5'h00;
            stS1 <= 3'h0;
            stS2 <= 3'h0;
            ioS1 <= 8'h00;
            ioS2 <= 8'h00;
            wgS1 <= '0;
            wgS2 <= '0;
        end else begin
            ffS1 <= fieldFlags;
            ffS2 <= ffS1;
            stS1 <= {overrun, full, aFull};
            stS2 <= stS1;
            ioS1 <= ioIn;
            ioS2 <= ioS1;
            wgS1 <= wgray;
            wgS2 <= wgS1;
        end
    end

    assign empty = (rgray == wgS2); // [R15]
    assign statReg = {4'h0, stS2, empty}; // [R15]
    // packet words leave only in packet mode, never enter
    assign pop = portReady && portFnSel && rdWrSel && !empty; // [R16] [R17]

    // register read mux
    always_comb begin
        rdData = 8'h00; // unmapped reads give zero
        if (adIn[7:0] >= `ACDP_REG_PIN0 && adIn[7:0] <= `ACDP_REG_PIN7) begin
            rdData = {2'h0, pinCfg[3'(adIn[7:0] - `ACDP_REG_PIN0)]};
        end else begin
            unique case (adIn[7:0])
                `ACDP_REG_FFLAGS: rdData = {3'h0, ffS2};
                `ACDP_REG_TEST: rdData = testCtl;
                `ACDP_REG_ANCCTL: rdData = ancCtl;
                `ACDP_REG_MASK: rdData = copyMask;
                `ACDP_REG_IDM: rdData = idMatch;
                `ACDP_REG_STAT: rdData = statReg;
                default: rdData = 8'h00;
            endcase
        end
    end

    // port phase sequencer and pin drivers
    always_ff @(posedge aclk or negedge nrst) begin
        if (!nrst) begin
            state <= PS_IDLE;
            addr <= 8'h00;
            adOut <= 10'h000;
            adOe <= 1'b0; // [R25]
        end else begin
            adOe <= 1'b0; // [R25] receive unless a read phase follows
            if (!portReady) begin
                state <= PS_IDLE;
            end else if (portFnSel) begin
                state <= PS_IDLE;
                if (pop) begin
                    adOut <= mem[rptr[AW-1:0]]; // [R16]
                    adOe <= 1'b1;
                end
            end else begin
                unique case (state)
                    PS_IDLE: begin
                        if (adIn[9:8] == `ACDP_Q_ADDR) begin // [R2]
                            addr <= adIn[7:0]; // [R7]
                            if (rdWrSel) begin // [R6]
                                adOut <= {`ACDP_Q_READ, rdData}; // [R4] [R1]
                                adOe <= 1'b1; // [R8]
                                state <= PS_RDRV;
                            end else begin
                                state <= PS_WDATA; // [R10]
                            end
                        end
                    end
                    // next edge releases the port
                    PS_RDRV: state <= PS_IDLE; // [R8] [R9]
                    PS_WDATA: state <= PS_IDLE; // [R10]
                endcase
            end
        end
    end

    // a write needs the data qualifier; others are dropped
    assign wrEn = portReady && !portFnSel && !rdWrSel && (state == PS_WDATA)
        && (adIn[9:8] == `ACDP_Q_DATA); // [R3] [R1]

    // writable registers, then input pins clocked in
    always_ff @(posedge aclk or negedge nrst) begin
        if (!nrst) begin
            testCtl <= 8'h00; // [R24]
            ancCtl <= 8'h00; // [R18] capture off
            copyMask <= 8'h00;
            idMatch <= 8'h00;
            for (int i = 0; i < 8; i++) begin
                pinCfg[i] <= 6'h00;
            end
        end else begin
            if (wrEn) begin
                if (addr >= `ACDP_REG_PIN0 && addr <= `ACDP_REG_PIN7) begin
                    pinCfg[3'(addr - `ACDP_REG_PIN0)] <= adIn[5:0]; // [R20]
                end
                unique case (addr)
                    `ACDP_REG_TEST: testCtl <= adIn[7:0];
                    `ACDP_REG_ANCCTL: ancCtl <= adIn[7:0]; // [R18]
                    `ACDP_REG_MASK: copyMask <= adIn[7:0]; // [R14]
                    `ACDP_REG_IDM: idMatch <= adIn[7:0]; // [R14]
                    default: ;
                endcase
            end
            // read-only groups ignore pin inputs; two pins on one bit
            // resolve to the higher pin
            for (int i = 0; i < 8; i++) begin
                if (portReady && !pinCfg[i][`ACDP_PIN_DIR_BIT]) begin
                end else if (portReady && pinCfg[i][4:3] == 2'h0) begin
                    testCtl[pinCfg[i][2:0]] <= ioS2[i]; // [R22] [R21]
                end else if (portReady && pinCfg[i][4:3] == 2'h1) begin
                    ancCtl[pinCfg[i][2:0]] <= ioS2[i]; // [R22]
                end
            end
        end
    end

    // per-pin selected indicator, latched for the crossing
    always_ff @(posedge aclk or negedge nrst) begin
        if (!nrst) begin
            pinVal <= 8'h00;
        end else begin
            for (int i = 0; i < 8; i++) begin
                pinVal[i] <= mapBit(pinCfg[i][4:0], testCtl, ancCtl, statReg, ffS2); // [R23]
            end
        end
    end

    // read pointer, gray copy for the crossing
    always_ff @(posedge aclk or negedge nrst) begin
        if (!nrst) begin
            rptr <= '0; // [R24]
            rgray <= '0;
        end else if (pop) begin
            rptr <= rptr + 1'b1;
            rgray <= bin2gray(rptr + 1'b1);
        end
    end

    // synchronisers into core_clk: config is quasi-static
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            xS1 <= '0;
            xS2 <= '0;
            rgS1 <= '0;
            rgS2 <= '0;
        end else begin
            xS1 <= {ancCtl[`ACDP_FIFOEN_BIT], copyMask, idMatch, pinVal, ~pinOeDir()};
            xS2 <= xS1;
            rgS1 <= rgray;
            rgS2 <= rgS1;
        end
    end
    // output enable per pin: direction bit low means output
    function automatic logic [7:0] pinOeDir();
        logic [7:0] d;
        for (int i = 0; i < 8; i++) begin
            d[i] = pinCfg[i][`ACDP_PIN_DIR_BIT];
        end
        return d;
    endfunction

    // pins follow indicators every video clock
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            ioOut <= 8'h00;
            ioOe <= 8'h00;
        end else begin
            ioOut <= xS2[15:8]; // [R23]
            ioOe <= xS2[7:0]; // [R20]
        end
    end

    // packets ride the colour-difference half in hd; sd uses it too
    assign chroma = videoIn[9:0]; // [R13]

    // video passes untouched, packets stay in it
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            chromaVideoOut <= 10'h000;
        end else begin
            chromaVideoOut <= chroma; // [R12]
        end
    end

    // mask bit set means that identifier bit must match
    assign hit = xS2[32] && (((chroma[7:0] ^ xS2[23:16]) & xS2[31:24]) == 8'h00); // [R14] [R18]

    // packet parser: flag words are matched but never stored
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            pk <= PK_SEEK;
            adfCnt <= 2'h0;
            remain <= 9'h000;
            keep <= 1'b0;
        end else if (videoValid) begin
            unique case (pk)
                PK_SEEK: begin
                    if (chroma == `ACDP_ADF0) begin
                        adfCnt <= 2'h1;
                    end else if (chroma == `ACDP_ADF1 && adfCnt == 2'h1) begin
                        adfCnt <= 2'h2;
                    end else if (chroma == `ACDP_ADF1 && adfCnt == 2'h2) begin
                        adfCnt <= 2'h0;
                        pk <= PK_DID; // [R12]
                    end else begin
                        adfCnt <= 2'h0;
                    end
                end
                PK_DID: begin
                    keep <= hit; // [R14]
                    pk <= PK_SDID;
                end
                PK_SDID: pk <= PK_DC;
                PK_DC: begin
                    remain <= {1'b0, chroma[7:0]} + 9'h001; // user words plus checksum
                    pk <= PK_BODY;
                end
                PK_BODY: begin
                    remain <= remain - 9'h001;
                    if (remain == 9'h001) begin
                        pk <= PK_SEEK;
                    end
                end
            endcase
        end
    end

    assign wrReq = videoValid && ((pk == PK_DID) ? hit : (pk != PK_SEEK && keep));
    assign occ = wptr - gray2bin(rgS2);
    assign full = (occ >= (AW + 1)'(DEPTH)); // [R11] [R15]
    assign aFull = (occ >= (AW + 1)'(AFULL)); // [R15]
    assign wrDo = wrReq && !full;

    // write pointer and sticky overrun
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            wptr <= '0; // [R24]
            wgray <= '0;
            overrun <= 1'b0;
        end else begin
            if (wrDo) begin
                wptr <= wptr + 1'b1;
                wgray <= bin2gray(wptr + 1'b1);
            end
            if (wrReq && full) begin
                overrun <= 1'b1; // [R15] cleared only by reset
            end
        end
    end

    // buffer storage, no reset on the array
    always_ff @(posedge core_clk) begin
        if (wrDo) begin
            mem[wptr[AW-1:0]] <= chroma; // [R11]
        end
    end
endmodule

// File: dv/acdp_port_assertions.sv
/*
 * checker for the auxiliary port, watching the top module's ports only.
 * assumes binding onto acdp_port; aclk may stand still between transfers.
 */
`timescale 1ns/1ps
module acdp_port_chk (
    input wire logic core_clk, // video word clock
    input wire logic nrst, // async reset, low
    input wire logic aclk, // host strobe
    input wire logic portFnSel, // packet buffer mode
    input wire logic rdWrSel, // read select
    input wire logic [9:0] adIn, // port pins in
    input wire logic [9:0] adOut, // port pins out
    input wire logic adOe, // port drive enable
    input wire logic [7:0] ioIn, // pins in
    input wire logic [7:0] ioOut, // pins out
    input wire logic [7:0] ioOe, // pins enable
    input wire logic [19:0] videoIn, // video words
    input wire logic videoValid, // video valid
    input wire logic [4:0] fieldFlags, // error flags
    input wire logic [9:0] chromaVideoOut // chroma out
);
    logic [1:0] edgeCnt; // strobe edges since reset, saturates at 3
    // counts the initialisation strobes the port must ignore
    always_ff @(posedge aclk or negedge nrst) begin
        if (!nrst) begin
            edgeCnt <= 2'h0;
        end else if (edgeCnt != 2'h3) begin
            edgeCnt <= edgeCnt + 2'h1;
        end
    end
    rd_qual_a: assert property (@(posedge aclk) disable iff (!nrst)
        adOe && !$past(portFnSel) |-> adOut[9:8] == 2'b10) else $error("read qualifier wrong");
    rd_addr_a: assert property (@(posedge aclk) disable iff (!nrst)
        adOe && !$past(portFnSel) |-> $past(rdWrSel) && $past(adIn[9:8]) == 2'b00) else $error("read without address");
    rd_release_a: assert property (@(posedge aclk) disable iff (!nrst)
        adOe && !$past(portFnSel) |=> !adOe) else $error("read data held too long");
    no_anc_write_a: assert property (@(posedge aclk) disable iff (!nrst)
        portFnSel && !rdWrSel |=> !adOe) else $error("drive in buffer write mode");
    oe_cause_a: assert property (@(posedge aclk) disable iff (!nrst)
        $rose(adOe) |-> $past(rdWrSel)) else $error("drive without read request");
    init_quiet_a: assert property (@(posedge aclk) disable iff (!nrst)
        edgeCnt < 2'h3 |=> !adOe) else $error("drive during initialisation");
    chroma_pass_a: assert property (@(posedge core_clk) disable iff (!nrst)
        $past(nrst) |-> chromaVideoOut == $past(videoIn[9:0])) else $error("chroma not passed");
    reset_quiet_a: assert property (@(posedge core_clk)
        !nrst |-> !adOe && ioOut == 8'h00 && ioOe == 8'h00) else $error("outputs active in reset");
endmodule

// File: dv/acdp_host_model.sv
/*
 * host controller model: strobes, mode selects and the shared port pins.
 * assumes the bench calls its tasks one at a time; strobe stands still between them.
 */
`timescale 1ns/1ps
module acdp_host_model (
    output logic aclk, // strobe, 15 ns period
    output logic portFnSel, // port mode
    output logic rdWrSel, // read select
    output logic [9:0] adIn, // resolved port pins
    input wire logic [9:0] adOut, // device pins out
    input wire logic adOe // device drive enable
);
    logic drv; // host drives the pins
    logic [9:0] hv; // host pin value
    // released pins show the inverse, so a stale value never passes
    assign adIn = drv ? hv : (adOe ? adOut : ~hv);
    initial begin
        aclk = 1'b0;
        portFnSel = 1'b0;
        rdWrSel = 1'b0;
        drv = 1'b0;
        hv = 10'h000;
    end
    task rise;
        #7.5 aclk = 1'b1;
    endtask
    task fall;
        #7.5 aclk = 1'b0;
    endtask
    // idle strobes carry a qualifier that is never an address
    task idle(input int n);
        portFnSel = 1'b0;
        rdWrSel = 1'b0;
        drv = 1'b1;
        hv = 10'h1ff;
        repeat (n) begin
            rise;
            fall;
        end
        drv = 1'b0;
    endtask
    task wr(input logic [7:0] a, input logic [9:0] w);
        portFnSel = 1'b0;
        rdWrSel = 1'b0;
        drv = 1'b1;
        hv = {2'b00, a};
        rise;
        fall;
        hv = w;
        rise;
        fall;
        drv = 1'b0;
    endtask
    // address released right after capture to avoid contention
    task rd(input logic [7:0] a, output logic [9:0] d, output logic oe);
        portFnSel = 1'b0;
        rdWrSel = 1'b1;
        drv = 1'b1;
        hv = {2'b00, a};
        rise;
        #1 drv = 1'b0;
        #6.5 aclk = 1'b0;
        #7 d = adOut;
        oe = adOe;
        #0.5 aclk = 1'b1;
        fall;
    endtask
    task pop(input logic rw, output logic [9:0] d, output logic oe);
        portFnSel = 1'b1;
        rdWrSel = rw;
        drv = 1'b0;
        rise;
        fall;
        #7 d = adOut;
        oe = adOe;
    endtask
endmodule

// File: dv/tb_top.sv
/*
 * self-checking bench for the auxiliary port: registers, packet buffer, pins.
 * assumes acdp_host_model plays the host and the checker is bound below.
 */
`timescale 1ns/1ps
module tb_top;
    logic core_clk, nrst, aclk, portFnSel, rdWrSel, adOe, videoValid;
    logic [9:0] adIn, adOut, chromaVideoOut;
    logic [7:0] ioIn, ioOut, ioOe;
    logic [19:0] videoIn;
    logic [4:0] fieldFlags;
    int n_fail, total_checks;
    // stored words: identifier, second identifier, count of three, three user words, checksum
    logic [9:0] pk [7] = '{10'h241, 10'h101, 10'h203, 10'h123, 10'h0aa, 10'h155, 10'h2c4};
    acdp_host_model host (.aclk(aclk), .portFnSel(portFnSel), .rdWrSel(rdWrSel), .adIn(adIn),
        .adOut(adOut), .adOe(adOe));
    acdp_port dut (.core_clk(core_clk), .nrst(nrst), .aclk(aclk), .portFnSel(portFnSel),
        .rdWrSel(rdWrSel), .adIn(adIn), .adOut(adOut), .adOe(adOe), .ioIn(ioIn), .ioOut(ioOut),
        .ioOe(ioOe), .videoIn(videoIn), .videoValid(videoValid), .fieldFlags(fieldFlags),
        .chromaVideoOut(chromaVideoOut));
    always #25 core_clk = ~core_clk;
    task chk(input string nm, input logic [9:0] e, input logic [9:0] g);
        total_checks++;
        if (g !== e) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task tally_and_finish;
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task rdc(input logic [7:0] a, input logic [7:0] e);
        logic [9:0] d;
        logic oe;
        host.rd(a, d, oe);
        chk($sformatf("reg%h", a), {2'b10, e}, d);
        chk("regOe", 10'h001, {9'h0, oe});
    endtask
    // polls status, bounded, instead of guessing the crossing delay
    task pollst(input logic [7:0] e);
        logic [9:0] d;
        logic oe;
        for (int i = 0; i < 20; i++) begin
            host.rd(8'h1a, d, oe);
            if (d[7:0] === e) break;
        end
        chk("status", {2'b10, e}, d);
    endtask
    // flag words first, then the packet; luma puts it on the upper channel
    task send(input bit luma);
        logic [9:0] w;
        for (int i = 0; i < 10; i++) begin
            w = (i == 0) ? 10'h000 : (i < 3) ? 10'h3ff : pk[i - 3];
            @(posedge core_clk);
            videoIn <= luma ? {w, 10'h000} : {10'h000, w};
            videoValid <= 1'b1;
        end
        @(posedge core_clk);
        videoValid <= 1'b0;
        videoIn <= 20'h00000;
    endtask
    task drain;
        logic [9:0] d;
        logic oe;
        for (int i = 0; i < 7; i++) begin
            host.pop(1'b1, d, oe);
            chk("word", pk[i], d);
            chk("wordOe", 10'h001, {9'h0, oe});
        end
        host.pop(1'b1, d, oe);
        chk("emptyOe", 10'h000, {9'h0, oe});
    endtask
    task t_reset;
        rdc(8'h17, 8'h00);
        rdc(8'h18, 8'h00);
        rdc(8'h19, 8'h00);
        rdc(8'h0f, 8'h00);
        rdc(8'h1a, 8'h01);
        rdc(8'h40, 8'h00);
        rdc(8'h01, 8'h15);
        // flags change, two strobes let the synchroniser catch up
        @(posedge core_clk);
        fieldFlags <= ~fieldFlags;
        host.idle(2);
        rdc(8'h01, 8'h0a);
        $display("t_reset done");
    endtask
    task t_regs;
        host.wr(8'h18, 10'h3aa);
        rdc(8'h18, 8'haa);
        host.wr(8'h18, 10'h155);
        rdc(8'h18, 8'haa);
        host.wr(8'h1a, 10'h300);
        rdc(8'h1a, 8'h01);
        host.wr(8'h19, 10'h355);
        rdc(8'h19, 8'h55);
        host.wr(8'h18, 10'h300);
        host.wr(8'h19, 10'h300);
        $display("t_regs done");
    endtask
    // every pin maps test bit 0 after reset; pin 1 turned into an input
    task t_pins;
        chk("ioOe", 10'h0ff, {2'b00, ioOe});
        host.wr(8'h0d, 10'h301);
        host.idle(3);
        repeat (6) @(posedge core_clk);
        chk("ioOut", 10'h0ff, {2'b00, ioOut});
        host.wr(8'h10, 10'h321);
        @(posedge core_clk);
        ioIn <= 8'h02;
        host.idle(4);
        rdc(8'h0d, 8'h03);
        repeat (6) @(posedge core_clk);
        chk("ioOe1", 10'h0fd, {2'b00, ioOe});
        chk("ioOut1", 10'h0fd, {2'b00, ioOut & ioOe});
        // input pin low again: its register bit must follow
        @(posedge core_clk);
        ioIn <= ioIn ^ 8'h02;
        host.idle(4);
        rdc(8'h0d, 8'h01);
        $display("t_pins done");
    endtask
    task t_pkt;
        logic [9:0] d;
        logic oe;
        send(1'b0);
        host.idle(4);
        rdc(8'h1a, 8'h01);
        host.wr(8'h17, 10'h340);
        host.idle(3);
        send(1'b0);
        pollst(8'h00);
        host.pop(1'b0, d, oe);
        chk("wrModeOe", 10'h000, {9'h0, oe});
        drain;
        rdc(8'h1a, 8'h01);
        $display("t_pkt done");
    endtask
    task t_filt;
        host.wr(8'h18, 10'h3ff);
        host.wr(8'h19, 10'h345);
        send(1'b0);
        host.wr(8'h19, 10'h341);
        send(1'b1);
        host.idle(4);
        rdc(8'h1a, 8'h01);
        send(1'b0);
        pollst(8'h00);
        drain;
        $display("t_filt done");
    endtask
    initial begin
        core_clk = 1'b0;
        nrst = 1'b1;
        ioIn = 8'h00;
        videoIn = 20'h00000;
        videoValid = 1'b0;
        fieldFlags = 5'h15;
        n_fail = 0;
        total_checks = 0;
        // a clean falling edge, so the asynchronous reset is never missed
        #1 nrst = 1'b0;
        host.idle(1);
        repeat (12) @(posedge core_clk);
        nrst <= 1'b1;
        @(posedge core_clk);
        #3 host.idle(3);
        t_reset;
        t_regs;
        t_pins;
        t_pkt;
        t_filt;
        tally_and_finish;
    end
    // cuts a hang short
    initial begin
        #3000000;
        n_fail++;
        tally_and_finish;
    end
endmodule
bind acdp_port acdp_port_chk chk (.core_clk(core_clk), .nrst(nrst), .aclk(aclk), .portFnSel(portFnSel),
    .rdWrSel(rdWrSel), .adIn(adIn), .adOut(adOut), .adOe(adOe), .ioIn(ioIn), .ioOut(ioOut), .ioOe(ioOe),
    .videoIn(videoIn), .videoValid(videoValid), .fieldFlags(fieldFlags), .chromaVideoOut(chromaVideoOut));
